// >>> core/gate_arm_pkg.sv
package gate_arm_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_DIGITS = 8'h04;
  localparam logic [7:0] ADDR_GATE   = 8'h08;
  localparam logic [7:0] ADDR_EXP1   = 8'h0c;
  localparam logic [7:0] ADDR_EXP2   = 8'h10;
  localparam logic [7:0] ADDR_EXP3   = 8'h14;
  localparam logic [7:0] ADDR_AUTO   = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_EVCNT  = 8'h20;
  localparam logic [7:0] ADDR_TBCNT  = 8'h24;
  localparam logic [7:0] ADDR_CH3    = 8'h28;
  localparam logic [7:0] ADDR_CMD    = 8'h2c;
  // Control field positions and reset value
  localparam int CTRL_W = 13;
  localparam int F_START_SRC = 0;
  localparam int F_START_EDGE = 1;
  localparam int F_STOP_LSB = 2;
  localparam int F_STOP_EDGE = 4;
  localparam int F_FN_LSB = 5;
  localparam int F_CHA_LSB = 8;
  localparam int F_CHB_LSB = 10;
  localparam int F_HI_RANGE = 12;
  localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0918;
  // Arm sources
  localparam logic       START_IMM = 1'h0;
  localparam logic       START_EXT = 1'h1;
  localparam logic [1:0] STOP_IMM  = 2'h0;
  localparam logic [1:0] STOP_EXT  = 2'h1;
  localparam logic [1:0] STOP_TIM  = 2'h2;
  localparam logic [1:0] STOP_DIG  = 2'h3;
  // Sensor functions
  localparam logic [2:0] FN_FREQ  = 3'h0;
  localparam logic [2:0] FN_PER   = 3'h1;
  localparam logic [2:0] FN_RATIO = 3'h2;
  localparam logic [2:0] FN_PHASE = 3'h3;
  localparam logic [2:0] FN_TINT  = 3'h4;
  localparam logic [2:0] FN_TOT   = 3'h5;
  // Digits resolution
  localparam logic [3:0] DIG_MIN = 4'h3;
  localparam logic [3:0] DIG_MAX = 4'hf;
  localparam logic [3:0] DIG_RST = 4'h4;
  // Gate time, counted in 10 us steps
  localparam int GATE_STEP_NS  = 10000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int GATE_W = 27;
  localparam logic [GATE_W-1:0] GATE_SHORT_MIN = 27'h0000064;
  localparam logic [GATE_W-1:0] GATE_SHORT_MAX = 27'h000270f;
  localparam logic [GATE_W-1:0] GATE_LONG_MIN  = 27'h0002710;
  localparam logic [GATE_W-1:0] GATE_LONG_MAX  = 27'h5f5e100;
  localparam logic [GATE_W-1:0] GATE_LONG_STEP = 27'h0000064;
  localparam logic [GATE_W-1:0] GATE_RST       = 27'h0002710;
  // Expected frequency: ch1/2 in 0.1 Hz, ch3 in kHz
  localparam logic [31:0] EXP12_MIN  = 32'h00000001;
  localparam logic [31:0] EXP12_MAX  = 32'h861c4680;
  localparam logic [31:0] EXP3L_MIN  = 32'h000186a0;
  localparam logic [31:0] EXP3L_MAX  = 32'h002dc6c0;
  localparam logic [31:0] EXP3H_MIN  = 32'h00030d40;
  localparam logic [31:0] EXP3H_MAX  = 32'h004c4b40;
  // Answers
  localparam logic [31:0] NAN_CODE     = 32'hffffffff;
  localparam logic [15:0] ERR_SETTINGS = 16'hff23;
  localparam logic [31:0] CH3_LEVEL    = 32'h00000000;
  localparam logic        CH3_SLOPE_POS = 1'h1;
  localparam logic [39:0] DIG_LIMIT_CAP = 40'he8d4a51000;
  // Gate sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_OPEN = 4'b0100,
    ST_DONE = 4'b1000
  } gate_state_t;
endpackage : gate_arm_pkg

// >>> core/counter_gate_arming_control.sv
`timescale 1ns/10ps
module counter_gate_arming_control
  import gate_arm_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  // Wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // Measured inputs and external arm pin
  input  wire logic        i_ch1,
  input  wire logic        i_ch2,
  input  wire logic        i_ch3,
  input  wire logic        i_ext_arm,
  // Measurement status
  output logic             o_gate_open,
  output logic             o_meas_done,
  output logic      [2:0]  o_auto_premeas
);
  localparam int TICK_CYC = GATE_STEP_NS / CLK_PERIOD_NS;

  // The gate counts in 10 us ticks made by a divider of the system clock.
  // At 50 MHz that is 500 cycles a tick, so a 1000 s gate needs 27 bits
  // of tick count, while the tick divider itself stays at 9 bits.
  // Everything below runs on i_clk_sys alone; the pins are synchronised first.
  // Limitation: the tick length follows CLK_PERIOD_NS, so a new clock needs a new package.

  // Start/stop pair check
  // Six pairs are legal. Immediate start refuses an external stop and
  // external start refuses a digits stop; every other combination passes.
  // The check runs on the incoming word, so a refused pair never lands.
  function automatic logic pair_ok(input logic st, input logic [1:0] sp);
    pair_ok = (st == START_IMM) ? (sp != STOP_EXT) : (sp != STOP_DIG);
  endfunction : pair_ok

  // Function and channel check
  // Channel codes are 1, 2 and 3; code 0 means no channel at all.
  // Ratio needs channel one on one side and two or three on the other.
  // Phase and interval are fixed to channel one then channel two.
  // Codes above totalize are refused outright.
  function automatic logic func_ok(input logic [2:0] fn, input logic [1:0] a, input logic [1:0] b);
    case (fn)
      FN_FREQ, FN_PER: func_ok = (a != 2'h0);
      FN_RATIO: func_ok = (a == 2'h1 && (b == 2'h2 || b == 2'h3)) || (b == 2'h1 && (a == 2'h2 || a == 2'h3));
      FN_PHASE, FN_TINT: func_ok = (a == 2'h1) && (b == 2'h2);
      FN_TOT: func_ok = (a == 2'h1);
      default: func_ok = 1'b0;
    endcase
  endfunction : func_ok

  // Gate length check in 10 us steps
  // Short gates take any tick count from 100 to 9999.
  // Long gates must be whole milliseconds, that is multiples of 100 ticks.
  // Values outside both bands are refused.
  // The modulo is by a constant, so it folds into plain compare logic.
  function automatic logic gate_ok(input logic [GATE_W-1:0] g);
    gate_ok = (g >= GATE_SHORT_MIN && g <= GATE_SHORT_MAX)
           || (g >= GATE_LONG_MIN && g <= GATE_LONG_MAX && (g % GATE_LONG_STEP) == '0);
  endfunction : gate_ok

  // Expected frequency range check
  // lo selects the channel one and two scale, in 0.1 Hz units.
  // Channel three is in kHz; hi picks the higher range option.
  // A refused value leaves auto pre-measurement untouched.
  // Zero is below every band, so it can never switch auto off.
  function automatic logic exp_ok(input logic lo, input logic hi, input logic [31:0] v);
    exp_ok = lo ? (v >= EXP12_MIN && v <= EXP12_MAX)
         : hi ? (v >= EXP3H_MIN && v <= EXP3H_MAX) : (v >= EXP3L_MIN && v <= EXP3L_MAX);
  endfunction : exp_ok

  // Timebase cycles that give the requested digits of resolution
  // The result is ten to the power of the digit count, capped at 10^12,
  // so that fifteen digits still end in finite time.
  // The loop has a fixed bound, so it unrolls into plain logic.
  // Limitation: this is a time budget, not a measured resolution.
  function automatic logic [39:0] digit_limit(input logic [3:0] d);
    logic [39:0] v;
    v = 40'h1;
    for (int i = 0; i < 15; i++) begin
      if (i < int'(d) && v < DIG_LIMIT_CAP) begin
        v = v * 40'ha;
      end
    end
    digit_limit = v;
  endfunction : digit_limit


  // Configuration state
  logic [CTRL_W-1:0] ctrl_reg;
  logic [3:0]        digits_reg;
  logic [GATE_W-1:0] gate_reg;
  logic [31:0]       exp_reg [3];
  logic [2:0]        auto_reg;
  logic [15:0]       err_reg;

  // Bus answer
  logic              ack_reg;
  logic [31:0]       rdat_reg;

  // Pin synchronisers and edge history
  logic [3:0]        sync1_reg;
  logic [3:0]        sync2_reg;
  logic [3:0]        prev_reg;

  // Gate sequencer and its counters
  gate_state_t       state_reg;
  gate_state_t       state_next;
  logic [31:0]       ev_cnt_reg;
  logic [39:0]       tb_cnt_reg;
  logic [8:0]        tick_reg;
  logic [GATE_W-1:0] gate_cnt_reg;


  // Bus decode; writes land on the edge that sees ack, matching the master's sample point
  // A write whose byte enables are not all set is acknowledged and dropped.
  // Unmapped addresses are acknowledged too; reads of them return zero.
  // wr_cmd needs bit 0 set, so a zero write to the command word is harmless.
  // Decoding on ack keeps a held request from landing twice.
  wire req     = i_wb_cyc & i_wb_stb;
  wire wr      = req & i_wb_we & ack_reg & (i_wb_sel == 4'hf);
  wire rd_done = req & ~i_wb_we & ack_reg;
  wire wr_ctrl = wr & (i_wb_adr == ADDR_CTRL);
  wire wr_dig  = wr & (i_wb_adr == ADDR_DIGITS);
  wire wr_gate = wr & (i_wb_adr == ADDR_GATE);
  wire wr_auto = wr & (i_wb_adr == ADDR_AUTO);
  wire wr_stat = wr & (i_wb_adr == ADDR_STATUS);
  wire wr_cmd  = wr & (i_wb_adr == ADDR_CMD) & i_wb_dat[0];
  wire [2:0] wr_exp = {wr & (i_wb_adr == ADDR_EXP3), wr & (i_wb_adr == ADDR_EXP2), wr & (i_wb_adr == ADDR_EXP1)};
  wire [2:0] rd_exp = {i_wb_adr == ADDR_EXP3, i_wb_adr == ADDR_EXP2, i_wb_adr == ADDR_EXP1};

  // Write validation
  // Every check looks at the incoming word, not the stored one, so a refused
  // write never disturbs the setting in place.
  // Channel three's range option comes from the stored control word, so
  // setting the option and its expected frequency takes two accesses.
  wire [1:0] w_stop = i_wb_dat[F_STOP_LSB+:2];
  wire ctrl_ok = pair_ok(i_wb_dat[F_START_SRC], w_stop)
              & func_ok(i_wb_dat[F_FN_LSB+:3], i_wb_dat[F_CHA_LSB+:2], i_wb_dat[F_CHB_LSB+:2]);
  wire dig_ok  = (i_wb_dat[31:4] == '0) && i_wb_dat[3:0] >= DIG_MIN && i_wb_dat[3:0] <= DIG_MAX;
  wire g_ok    = (i_wb_dat[31:GATE_W] == '0) && gate_ok(i_wb_dat[GATE_W-1:0]);
  wire [2:0] e_ok;
  assign e_ok[0] = exp_ok(1'b1, 1'b0, i_wb_dat);
  assign e_ok[1] = e_ok[0];
  assign e_ok[2] = exp_ok(1'b0, ctrl_reg[F_HI_RANGE], i_wb_dat);
  wire nan_read = rd_done & |(rd_exp & auto_reg);
  wire bad_wr   = (wr_ctrl & ~ctrl_ok) | (wr_dig & ~dig_ok) | (wr_gate & ~g_ok)
                | |(wr_exp & ~e_ok) | (wr_auto & (i_wb_dat[2:0] != 3'h7) & (i_wb_dat[2:0] == 3'h0));


  // Control fields
  // Edge bits are kept even when their source is not external; they
  // take effect only once the matching source selects the pin.
  // Channel B is checked on write but not counted here.
  wire       start_src  = ctrl_reg[F_START_SRC];
  wire       start_fall = ctrl_reg[F_START_EDGE];
  wire [1:0] stop_src   = ctrl_reg[F_STOP_LSB+:2];
  wire       stop_fall  = ctrl_reg[F_STOP_EDGE];
  wire [1:0] cha        = ctrl_reg[F_CHA_LSB+:2];


  // Edges of the synchronised pins; channel three only ever yields rising events
  // prev_reg clears to the idle low level, so no false edge follows reset.
  // Only channel A feeds the event count and the immediate stop.
  // Falling edges are used for the arm pin alone.
  wire [3:0] rise = sync2_reg & ~prev_reg;
  wire [3:0] fall = ~sync2_reg & prev_reg;
  wire ev_a       = (cha == 2'h1) ? rise[0] : (cha == 2'h2) ? rise[1] : rise[2];
  wire start_hit  = start_fall ? fall[3] : rise[3];
  wire stop_hit   = stop_fall ? fall[3] : rise[3];
  wire tick       = (tick_reg == 9'(TICK_CYC - 1));


  // Stop condition per source
  // Only the selected source can end the gate; the others are ignored.
  // The timer compares the tick count against the stored gate length.
  // Digits compare the raw timebase count against the power of ten.
  wire stop_now = (stop_src == STOP_IMM) ? ev_a
                : (stop_src == STOP_EXT) ? stop_hit
                : (stop_src == STOP_TIM) ? (gate_cnt_reg >= gate_reg)
                : (tb_cnt_reg >= digit_limit(digits_reg));


  // Read selection
  // Expected frequency reads show the not-a-number code while auto is on.
  // The channel-three word packs a zero level with the positive slope bit.
  // Timebase count reads return the low 32 bits only.
  // The chain is ordered so the NaN case shadows the stored value.
  wire [31:0] rd_mux =
      (i_wb_adr == ADDR_CTRL)   ? {19'h0, ctrl_reg} :
      (i_wb_adr == ADDR_DIGITS) ? {28'h0, digits_reg} :
      (i_wb_adr == ADDR_GATE)   ? {5'h0, gate_reg} :
      (|(rd_exp & auto_reg))    ? NAN_CODE :
      (i_wb_adr == ADDR_EXP1)   ? exp_reg[0] :
      (i_wb_adr == ADDR_EXP2)   ? exp_reg[1] :
      (i_wb_adr == ADDR_EXP3)   ? exp_reg[2] :
      (i_wb_adr == ADDR_AUTO)   ? {29'h0, auto_reg} :
      (i_wb_adr == ADDR_STATUS) ? {err_reg, 12'h0, state_reg} :
      (i_wb_adr == ADDR_EVCNT)  ? ev_cnt_reg :
      (i_wb_adr == ADDR_TBCNT)  ? tb_cnt_reg[31:0] :
      (i_wb_adr == ADDR_CH3)    ? (CH3_LEVEL | {31'h0, CH3_SLOPE_POS}) :
      32'h0;


  // Bus handshake: ack one cycle after the request, dropped the cycle after
  // Read data is registered every cycle; the master takes it with ack.
  // Trade-off: one wait state on every access buys a registered data path.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      ack_reg  <= req & ~ack_reg;
      rdat_reg <= rd_mux;
    end
  end


  // Configuration registers; a rejected write leaves the old setting in place
  // Reset gives start immediate, stop timer, a 100 ms gate and 4 digits.
  // Changing them while a gate is open takes effect at once.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctrl_reg   <= CTRL_RST;
      digits_reg <= DIG_RST;
      gate_reg   <= GATE_RST;
    end else begin
      if (wr_ctrl && ctrl_ok) begin
        ctrl_reg <= i_wb_dat[CTRL_W-1:0];
      end
      if (wr_dig && dig_ok) begin
        digits_reg <= i_wb_dat[3:0];
      end
      if (wr_gate && g_ok) begin
        gate_reg <= i_wb_dat[GATE_W-1:0];
      end
    end
  end


  // Expected frequency and auto pre-measurement per channel
  // Each channel is independent; zero bits of an auto write change nothing.
  // A stored expected value is cleared whenever auto comes back on.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      auto_reg <= 3'h7;
      for (int c = 0; c < 3; c++) begin
        exp_reg[c] <= 32'h0;
      end
    end else begin
      for (int c = 0; c < 3; c++) begin
        if (wr_auto && i_wb_dat[c]) begin
          auto_reg[c] <= 1'b1;
          exp_reg[c]  <= 32'h0;
        end else if (wr_exp[c] && e_ok[c]) begin
          auto_reg[c] <= 1'b0;
          exp_reg[c]  <= i_wb_dat;
        end
      end
    end
  end


  // Error code: a new error wins over a clear in the same cycle
  // Only one code is kept; the latest refused access overwrites it.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      err_reg <= 16'h0;
    end else if (nan_read || bad_wr) begin
      err_reg <= ERR_SETTINGS;
    end else if (wr_stat && i_wb_dat[0]) begin
      err_reg <= 16'h0;
    end
  end


  // Two-stage synchronisers, then a plain edge history
  // The pins are asynchronous; only sync2_reg reads sync1_reg.
  // Cost: about three cycles from a pin edge to a gate action.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      prev_reg  <= 4'h0;
    end else begin
      sync1_reg <= {i_ext_arm, i_ch3, i_ch2, i_ch1};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end


  // Gate sequencer
  // A start command is ignored while a gate is pending or open.
  // There is no abort: a gate waiting for an external edge waits for it,
  // and only a reset returns the sequencer to idle.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE, ST_DONE: begin
        if (wr_cmd) begin
          state_next = (start_src == START_EXT) ? ST_WAIT : ST_OPEN;
        end
      end
      ST_WAIT: begin
        if (start_hit) begin
          state_next = ST_OPEN;
        end
      end
      ST_OPEN: begin
        if (stop_now) begin
          state_next = ST_DONE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Sequencer state register; reset returns it to idle
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end


  // Event, timebase and 10 us gate counters; cleared as the gate is armed
  // They hold their final values after the gate closes so they can be read.
  // The 32-bit event count wraps silently on very long gates.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || (state_reg != ST_OPEN && state_next != ST_IDLE && state_next != ST_DONE)) begin
      ev_cnt_reg   <= 32'h0;
      tb_cnt_reg   <= 40'h0;
      tick_reg     <= 9'h0;
      gate_cnt_reg <= '0;
    end else if (state_reg == ST_OPEN) begin
      ev_cnt_reg   <= ev_cnt_reg + 32'(ev_a);
      tb_cnt_reg   <= tb_cnt_reg + 40'h1;
      tick_reg     <= tick ? 9'h0 : tick_reg + 9'h1;
      gate_cnt_reg <= gate_cnt_reg + GATE_W'(tick);
    end
  end


  // Outputs
  // Ack and read data are registered; gate status comes from the state register.
  // No output is a combinational path from a pin.
  assign o_wb_ack       = ack_reg;
  assign o_wb_dat       = rdat_reg;
  assign o_gate_open    = (state_reg == ST_OPEN);
  assign o_meas_done    = (state_reg == ST_DONE);
  assign o_auto_premeas = auto_reg;
endmodule : counter_gate_arming_control

// >>> tb/gate_arm_asserts.sv
`timescale 1ns/10ps
module gate_arm_asserts
  import gate_arm_pkg::*;
(
  // Clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_rst,
  // Register bus
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  // Status
  input wire logic        o_gate_open,
  input wire logic        o_meas_done,
  input wire logic [2:0]  o_auto_premeas
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // A read seen for the first time, before its acknowledge
  wire rd_req = i_wb_cyc & i_wb_stb & ~i_wb_we & ~o_wb_ack;

  chk_ack_pulse: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
    else $error("ack not a single pulse one cycle after request");
  chk_reset_auto: assert property ($fell(i_rst) |-> o_auto_premeas == 3'h7)
    else $error("auto pre-measurement not on after reset");
  chk_reset_gate: assert property ($fell(i_rst) |-> !o_gate_open && !o_meas_done)
    else $error("gate not idle after reset");
  chk_ch3_read: assert property ($past(rd_req && i_wb_adr == ADDR_CH3) && o_wb_ack |-> o_wb_dat == 32'h1)
    else $error("channel three level or slope wrong");
  chk_exp_nan: assert property ($past(rd_req && i_wb_adr == ADDR_EXP1 && o_auto_premeas[0]) && o_wb_ack
    |-> o_wb_dat == NAN_CODE)
    else $error("expected frequency read under auto not NaN");
  chk_auto_off: assert property ($fell(o_auto_premeas[0])
    |-> $past(o_wb_ack && i_wb_we && i_wb_adr == ADDR_EXP1))
    else $error("auto turned off without expected frequency write");
  chk_auto_on: assert property ($rose(o_auto_premeas[0])
    |-> $past(i_rst) || $past(o_wb_ack && i_wb_we && i_wb_adr == ADDR_AUTO))
    else $error("auto turned on without auto write");
  chk_gate_excl: assert property (!(o_gate_open && o_meas_done))
    else $error("gate open while done");
  chk_done_src: assert property ($rose(o_meas_done) |-> $past(o_gate_open))
    else $error("done without open gate");
endmodule : gate_arm_asserts

bind counter_gate_arming_control gate_arm_asserts chk_u (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
  .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_gate_open(o_gate_open),
  .o_meas_done(o_meas_done), .o_auto_premeas(o_auto_premeas)
);

// >>> tb/gate_signal_model.sv
`timescale 1ns/10ps
module gate_signal_model (
  // Clock and controls
  input  wire logic i_clk_sys,
  input  wire logic i_en,
  input  wire logic i_arm_req,
  // Measured inputs and arm pin
  output wire logic o_ch1,
  output wire logic o_ch2,
  output wire logic o_ch3,
  output wire logic o_ext_arm
);
  logic [3:0] div_reg = 4'h0;
  logic       arm_reg = 1'h0;
  // Free-running CW sources; lines rest low when no signal is applied
  always_ff @(posedge i_clk_sys) begin
    div_reg <= div_reg + 4'h1;
    arm_reg <= i_arm_req;
  end
  // Signals stay present while enabled so pre-measurement has something to see
  assign o_ch1 = i_en & div_reg[2];
  assign o_ch2 = i_en & div_reg[3];
  assign o_ch3 = i_en & div_reg[1];
  assign o_ext_arm = arm_reg;
endmodule : gate_signal_model

// >>> tb/counter_gate_arming_control_tb.sv
`timescale 1ns/10ps
module counter_gate_arming_control_tb import gate_arm_pkg::*;;
  logic        clk, rst, cyc, stb, we, ack, gate, done, ch1, ch2, ch3, ext, en, arm_req;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic [2:0]  auto_on;
  int          err_total, total_checks;

  counter_gate_arming_control dut_u (.i_clk_sys(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_ch1(ch1), .i_ch2(ch2), .i_ch3(ch3), .i_ext_arm(ext), .o_gate_open(gate), .o_meas_done(done),
    .o_auto_premeas(auto_on));
  gate_signal_model src_u (.i_clk_sys(clk), .i_en(en), .i_arm_req(arm_req), .o_ch1(ch1), .o_ch2(ch2),
    .o_ch3(ch3), .o_ext_arm(ext));

  task automatic conclude;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle; the wait is bounded since the slave could hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 20);
    if (ack !== 1'h1) begin
      err_total++;
      conclude();
    end
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    chk(q, e);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'h1, a, d);
  endtask : wr

  // Error field check, then clear it so the next case starts clean
  task automatic st(input logic [15:0] e);
    wb(1'h0, ADDR_STATUS, 32'h0);
    chk({16'h0, q[31:16]}, {16'h0, e});
    wr(ADDR_STATUS, 32'h1);
  endtask : st

  task automatic wait_gate(input logic lvl, input int lim, output int n);
    n = 0;
    while (gate !== lvl) begin
      @(posedge clk);
      n++;
      if (n > lim) begin
        err_total++;
        conclude();
      end
    end
  endtask : wait_gate

  task automatic t_reset;
    rd(ADDR_CTRL, {19'h0, CTRL_RST});
    rd(ADDR_DIGITS, 32'h4);
    rd(ADDR_GATE, 32'h2710);
    rd(ADDR_CH3, 32'h1);
    chk({29'h0, auto_on}, 32'h7);
    rd(ADDR_EXP3, NAN_CODE);
    st(ERR_SETTINGS);
    rd(8'h40, 32'h0);
  endtask : t_reset

  // Every start/stop pair; the two outside the legal set must be refused
  task automatic t_pairs;
    logic [31:0] v, last;
    last = {19'h0, CTRL_RST};
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 4; p++) begin
        v = {19'h0, CTRL_RST};
        v[0] = s[0];
        v[1] = s[0];
        v[3:2] = p[1:0];
        wr(ADDR_CTRL, v);
        if ((s == 0 && p == 1) || (s == 1 && p == 3)) begin
          st(ERR_SETTINGS);
        end else begin
          last = v;
        end
        rd(ADDR_CTRL, last);
      end
    end
  endtask : t_pairs

  // Boundary values of digits, gate time and expected frequencies
  task automatic t_ranges;
    logic [7:0]  ta [15] = '{ADDR_DIGITS, ADDR_DIGITS, ADDR_DIGITS, ADDR_GATE, ADDR_GATE, ADDR_GATE,
      ADDR_GATE, ADDR_GATE, ADDR_GATE, ADDR_EXP1, ADDR_EXP1, ADDR_EXP2, ADDR_EXP3, ADDR_EXP3, ADDR_EXP3};
    logic [31:0] tv [15] = '{32'h2, 32'h3, 32'hf, 32'h63, 32'h64, 32'h270f, 32'h2742, 32'h5f5e100,
      32'h5f5e164, 32'h0, 32'h861c4680, 32'h861c4681, 32'h1869f, 32'h2dc6c0, 32'h2dc6c1};
    logic        tk [15] = '{0, 1, 1, 0, 1, 1, 0, 1, 0, 0, 1, 0, 0, 1, 0};
    for (int i = 0; i < 15; i++) begin
      wr(ta[i], tv[i]);
      if (tk[i]) begin
        rd(ta[i], tv[i]);
      end else begin
        st(ERR_SETTINGS);
      end
    end
  endtask : t_ranges

  task automatic t_auto;
    chk({29'h0, auto_on}, 32'h2);
    wr(ADDR_AUTO, 32'h1);
    chk({29'h0, auto_on}, 32'h3);
    rd(ADDR_EXP1, NAN_CODE);
    st(ERR_SETTINGS);
    wr(ADDR_AUTO, 32'h0);
    st(ERR_SETTINGS);
    chk({29'h0, auto_on}, 32'h3);
    wr(ADDR_EXP2, 32'h3e8);
    chk({29'h0, auto_on}, 32'h1);
  endtask : t_auto

  // Immediate start; open time must land inside the stop source's window
  task automatic t_gate(input logic [31:0] c, input int lo, input int hi);
    int n;
    wr(ADDR_CTRL, c);
    wr(ADDR_CMD, 32'h1);
    wait_gate(1'h1, 10, n);
    wait_gate(1'h0, hi, n);
    chk({31'h0, done}, 32'h1);
    chk({31'h0, n >= lo}, 32'h1);
  endtask : t_gate

  // External start and stop; fe selects the falling start edge
  task automatic t_ext(input logic fe);
    int n;
    arm_req <= fe;
    wr(ADDR_CTRL, fe ? 32'h907 : 32'h915);
    wr(ADDR_CMD, 32'h1);
    repeat (20) @(posedge clk);
    chk({31'h0, gate}, 32'h0);
    arm_req <= ~fe;
    wait_gate(1'h1, 8, n);
    repeat (20) @(posedge clk);
    chk({31'h0, gate}, 32'h1);
    arm_req <= fe;
    wait_gate(1'h0, 8, n);
    chk({31'h0, done}, 32'h1);
  endtask : t_ext

  // Function and channel codes, then a partial byte-enable write
  task automatic t_func;
    wr(ADDR_CTRL, 32'hd58);
    rd(ADDR_CTRL, 32'hd58);
    wr(ADDR_CTRL, 32'he58);
    st(ERR_SETTINGS);
    rd(ADDR_CTRL, 32'hd58);
    wr(ADDR_CTRL, 32'h978);
    rd(ADDR_CTRL, 32'h978);
    wr(ADDR_CTRL, 32'h678);
    st(ERR_SETTINGS);
    rd(ADDR_CTRL, 32'h978);
    sel <= 4'h1;
    wr(ADDR_DIGITS, 32'h5);
    sel <= 4'hf;
    rd(ADDR_DIGITS, 32'hf);
    st(16'h0);
  endtask : t_func

  // Reset in mid-run must bring back the digits, control and auto defaults and an idle gate
  task automatic t_rerun;
    wr(ADDR_DIGITS, 32'h9);
    rst <= 1'h1;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rd(ADDR_DIGITS, 32'h4);
    rd(ADDR_CTRL, {19'h0, CTRL_RST});
    chk({29'h0, auto_on}, 32'h7);
    chk({30'h0, gate, done}, 32'h0);
  endtask : t_rerun

  // Free-running system clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // Main sequence
  initial begin
    rst = 1'h1;
    {cyc, stb, we, arm_req} = 4'h0;
    en = 1'h1;
    sel = 4'hf;
    adr = 8'h0;
    wdat = 32'h0;
    err_total = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_reset();
    t_pairs();
    t_ranges();
    t_func();
    t_auto();
    wr(ADDR_DIGITS, 32'h3);
    t_gate(32'h91c, 990, 1010);
    t_gate(32'h910, 1, 16);
    wr(ADDR_GATE, 32'h64);
    t_gate(32'h918, 49400, 50600);
    t_ext(1'h0);
    t_ext(1'h1);
    t_rerun();
    conclude();
  end
endmodule : counter_gate_arming_control_tb
